// file: common/ssvo_pkg.sv
/*
 * ssvo_pkg: constants and carrier types for the statistics vector output.
 * Assumes one ahb-lite master and an external counter device on the link.
 */
package ssvo_pkg;

  // =========================================================
  // register map
  localparam logic [7:0]  SSVO_CTRL_OFS  = 8'h00;
  localparam logic [7:0]  SSVO_STAT_OFS  = 8'h04;
  localparam logic [7:0]  SSVO_SENT_OFS  = 8'h08;
  localparam logic [7:0]  SSVO_LOST_OFS  = 8'h0C;
  localparam logic [31:0] SSVO_CTRL_RST  = 32'h0000_0001;
  localparam int          SSVO_EN_BIT    = 0;
  localparam int          SSVO_IMPURE_BIT = 7;

  // =========================================================
  // vector layout
  localparam logic [3:0] SSVO_RX_NIBS  = 4'h8;
  localparam logic [3:0] SSVO_TX_NIBS  = 4'hD;
  localparam logic [3:0] SSVO_IDLE_NIB = 4'hF;
  localparam logic [4:0] SSVO_MII_LOW  = 5'h18;

  // =========================================================
  // per-port receive status
  typedef struct packed {
    logic        fwd_blocked_flag;
    logic        pause_frame_seen;
    logic        ctrl_frame_seen;
    logic        ctrl_frame_bad_opcode;
    logic        prior_carrier_flag;
    logic        prior_valid_flag;
    logic        good_frame_flag;
    logic        bcast_flag;
    logic        mcast_flag;
    logic        checksum_bad_rx;
    logic        partial_byte_flag;
    logic        symbol_error_flag;
    logic        frame_dropped_flag;
    logic        impure_preamble;
    logic [10:0] in_byte_total;
  } ssvo_rx_info_type;

  // per-port transmit status
  typedef struct packed {
    logic        queue_id_mismatch;
    logic        queue_congested_flag;
    logic [11:0] out_bytes_with_retries;
    logic        pause_sent_flag;
    logic        ctrl_sent_flag;
    logic        send_complete_flag;
    logic        late_clash_flag;
    logic        defer_abort_flag;
    logic        retry_limit_abort;
    logic        underrun_flag;
    logic        oversize_flag;
    logic        deferred_flag;
    logic        bcast_flag;
    logic        mcast_flag;
    logic        checksum_bad_tx;
    logic [3:0]  attempt_tally;
    logic [10:0] out_byte_total;
  } ssvo_tx_info_type;

  typedef enum logic [0:0] {
    SSVO_IDLE  = 1'b0,
    SSVO_SHIFT = 1'b1
  } ssvo_state_type;

endpackage : ssvo_pkg

// file: design/ssvo_top.sv
/*
 * ssvo_top: per-port statistics probes, one shared 4-bit vector bus.
 * Assumes event pulses on ref_clk; the 6.25 MHz link clock arrives as an
 * asynchronous input and the counter logic samples data on its rising edge.
 */
`timescale 1ns/1ps
module ssvo_top
  import ssvo_pkg::*;
#(
  parameter int NPORT = 26
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // ahb-lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // port events
  input  wire logic [NPORT-1:0]             rx_ev,
  input  wire ssvo_rx_info_type [NPORT-1:0] rx_info,
  input  wire logic [NPORT-1:0]             tx_ev,
  input  wire ssvo_tx_info_type [NPORT-1:0] tx_info,
  // vector link
  input  wire logic                         stat_clk,
  output logic      [3:0]                   vec_data
);

  localparam int NSLOT = 2 * NPORT;

  // =========================================================
  // vector builders
  function automatic logic [31:0] build_rx(input ssvo_rx_info_type i,
                                           input logic [4:0] p,
                                           input logic impure_en);
    logic [31:0] v;
    v = 32'h0;
    v[31] = i.fwd_blocked_flag;
    v[30] = i.pause_frame_seen;
    v[29] = i.ctrl_frame_seen;
    v[28] = i.ctrl_frame_bad_opcode;
    v[27] = i.prior_carrier_flag;
    v[26] = i.prior_valid_flag;
    v[25] = i.good_frame_flag;
    v[24] = i.bcast_flag;
    v[23] = i.mcast_flag;
    v[22] = i.checksum_bad_rx;
    v[21] = i.partial_byte_flag;
    v[20] = i.symbol_error_flag & (p >= SSVO_MII_LOW);
    v[19] = i.frame_dropped_flag | (i.impure_preamble & impure_en);
    v[17:7] = i.in_byte_total;
    v[6:2] = p;
    v[1] = 1'b0;
    return v;
  endfunction : build_rx

  function automatic logic [48:0] build_tx(input ssvo_tx_info_type i,
                                           input logic [4:0] p);
    logic [48:0] v;
    v = 49'h0;
    v[48] = i.queue_id_mismatch;
    v[47] = i.queue_congested_flag;
    v[46:35] = i.out_bytes_with_retries;
    v[34] = i.pause_sent_flag;
    v[33] = i.ctrl_sent_flag;
    v[32] = i.send_complete_flag;
    v[31] = i.late_clash_flag;
    v[30] = i.defer_abort_flag;
    v[29] = i.retry_limit_abort;
    v[28] = i.underrun_flag;
    v[27] = i.oversize_flag;
    v[26] = i.deferred_flag;
    v[25] = i.bcast_flag;
    v[24] = i.mcast_flag;
    v[23] = i.checksum_bad_tx;
    v[22:19] = i.attempt_tally;
    v[17:7] = i.out_byte_total;
    v[6:2] = p;
    v[1] = 1'b1;
    return v;
  endfunction : build_tx

  // =========================================================
  // registers
  ssvo_state_type       state_q;
  logic [31:0]          ctrl_q;
  logic [31:0]          sent_q;
  logic [31:0]          lost_q;
  logic [31:0]          hrdata_q;
  logic                 wr_pend_q;
  logic [7:0]           wr_addr_q;
  logic [NPORT-1:0]     rx_pend_q;
  logic [NPORT-1:0]     tx_pend_q;
  logic [31:0]          rx_vec_q [NPORT];
  logic [48:0]          tx_vec_q [NPORT];
  logic [5:0]           scan_q;
  logic [51:0]          shift_q;
  logic [3:0]           nib_left_q;
  logic [3:0]           vec_data_q;
  logic                 lclk_meta_q;
  logic                 lclk_sync_q;
  logic                 lclk_prev_q;

  // =========================================================
  // link clock edges, counter logic samples on rise
  // sampled link clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lclk_meta_q <= 1'b0;
      lclk_sync_q <= 1'b0;
      lclk_prev_q <= 1'b0;
    end else begin
      lclk_meta_q <= stat_clk;
      lclk_sync_q <= lclk_meta_q;
      lclk_prev_q <= lclk_sync_q;
    end
  end

  wire link_fall = lclk_prev_q & ~lclk_sync_q;

  // =========================================================
  // slot selection: rx slots first, then tx slots
  wire        impure_en = ctrl_q[SSVO_IMPURE_BIT];
  wire        out_en    = ctrl_q[SSVO_EN_BIT];
  wire        sel_tx    = (scan_q >= 6'(NPORT));
  wire [5:0]  sel_port6 = sel_tx ? 6'(scan_q - 6'(NPORT)) : scan_q;
  wire [4:0]  sel_port  = sel_port6[4:0];
  wire        sel_pend  = sel_tx ? tx_pend_q[sel_port] : rx_pend_q[sel_port];
  wire        load      = (state_q == SSVO_IDLE) && out_en && sel_pend;
  wire [51:0] sel_vec   = sel_tx ? {3'h0, tx_vec_q[sel_port]}
                                 : {20'h0_0000, rx_vec_q[sel_port]};
  wire [3:0]  sel_nibs  = sel_tx ? SSVO_TX_NIBS : SSVO_RX_NIBS;

  // =========================================================
  // probes, one pair of slots per port
  // per-port probes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_pend_q <= '0;
      tx_pend_q <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        // event sets pending; set beats the load clear
        if (rx_ev[p]) begin
          rx_pend_q[p] <= 1'b1;
        end else if (load && !sel_tx && sel_port == 5'(p)) begin
          rx_pend_q[p] <= 1'b0;
        end
        if (tx_ev[p]) begin
          tx_pend_q[p] <= 1'b1;
        end else if (load && sel_tx && sel_port == 5'(p)) begin
          tx_pend_q[p] <= 1'b0;
        end
      end
    end
  end

  // vector storage, no reset needed on data
  always_ff @(posedge ref_clk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (rx_ev[p]) begin
        rx_vec_q[p] <= build_rx(rx_info[p], 5'(p), impure_en);
      end
      if (tx_ev[p]) begin
        tx_vec_q[p] <= build_tx(tx_info[p], 5'(p));
      end
    end
  end

  // =========================================================
  // serializer; a whole vector leaves before the next is picked
  // round-robin scan, no interleave
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scan_q <= 6'h00;
    end else if (!load) begin
      scan_q <= (scan_q == 6'(NSLOT - 1)) ? 6'h00 : 6'(scan_q + 6'h01);
    end
  end

  // low nibble first, pads are zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q    <= SSVO_IDLE;
      shift_q    <= '0;
      nib_left_q <= 4'h0;
      vec_data_q <= SSVO_IDLE_NIB;
    end else begin
      unique case (state_q)
        SSVO_IDLE: begin
          if (load) begin
            state_q    <= SSVO_SHIFT;
            shift_q    <= sel_vec;
            nib_left_q <= sel_nibs;
          end
        end
        SSVO_SHIFT: begin
          if (link_fall && nib_left_q != 4'h0) begin
            vec_data_q <= shift_q[3:0];
            shift_q    <= {4'h0, shift_q[51:4]};
            nib_left_q <= 4'(nib_left_q - 4'h1);
          end else if (link_fall) begin
            vec_data_q <= SSVO_IDLE_NIB;
            state_q    <= SSVO_IDLE;
          end
        end
      endcase
    end
  end

  assign vec_data = vec_data_q;

  // =========================================================
  // ahb-lite slave, zero wait states
  wire       ahb_take = hsel && htrans[1] && hready;
  wire       busy     = (state_q != SSVO_IDLE);
  wire       any_pend = |{rx_pend_q, tx_pend_q};
  wire [7:0] rd_ofs   = haddr[7:0];
  wire [31:0] rd_mux  = (rd_ofs == SSVO_CTRL_OFS) ? ctrl_q
                      : (rd_ofs == SSVO_STAT_OFS) ? {30'h0, any_pend, busy}
                      : (rd_ofs == SSVO_SENT_OFS) ? sent_q
                      : (rd_ofs == SSVO_LOST_OFS) ? lost_q
                      : 32'h0000_0000;
  // overwrites of a still pending slot lose the older vector;
  // a slot loaded in the same cycle already handed its vector on
  wire [NPORT-1:0] port_hot = {{(NPORT-1){1'b0}}, 1'b1} << sel_port;
  wire [NPORT-1:0] rx_taken = (load && !sel_tx) ? port_hot : '0;
  wire [NPORT-1:0] tx_taken = (load && sel_tx) ? port_hot : '0;
  wire [NPORT-1:0] lost_ev  = (rx_ev & rx_pend_q & ~rx_taken)
                            | (tx_ev & tx_pend_q & ~tx_taken);

  // address phase capture and read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= ahb_take && hwrite;
      wr_addr_q <= rd_ofs;
      if (ahb_take && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // control write and activity counters
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= SSVO_CTRL_RST;
      sent_q <= 32'h0000_0000;
      lost_q <= 32'h0000_0000;
    end else begin
      if (wr_pend_q && wr_addr_q == SSVO_CTRL_OFS) begin
        ctrl_q <= hwdata;
      end
      if (load) begin
        sent_q <= 32'(sent_q + 32'h1);
      end
      if (|lost_ev) begin
        lost_q <= 32'(lost_q + 32'h1);
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // =========================================================
  // assertions
  default clocking ast_cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_START_ZERO: assert property (load |=> shift_q[0] == 1'b0)
    else $error("start marker not zero");
  AST_TYPE_BIT: assert property (load |=> shift_q[1] == $past(sel_tx))
    else $error("type bit wrong");
  AST_PORT_FIELD: assert property (load |=> shift_q[6:2] == $past(sel_port))
    else $error("port field wrong");
  AST_RESERVED: assert property (load |=> shift_q[18] == 1'b0)
    else $error("reserved bit set");
  AST_NIB_COUNT: assert property (load |=> nib_left_q == (shift_q[1] ? 4'hD : 4'h8))
    else $error("nibble count wrong");
  AST_IDLE_HIGH: assert property (state_q == SSVO_IDLE |-> vec_data_q == 4'hF)
    else $error("lines not high when idle");
  AST_EVENT_PEND: assert property (rx_ev[0] |=> rx_pend_q[0])
    else $error("event not pending");
  AST_MII_ONLY: assert property (load && !sel_tx && sel_port < 5'h18
                                 |=> shift_q[20] == 1'b0)
    else $error("symbol error on non mii port");
  AST_LINK_TIMED: assert property ($changed(vec_data_q) |-> $past(link_fall))
    else $error("data changed off link edge");
  AST_PAD_ZERO: assert property (load && !sel_tx |=> shift_q[51:32] == 20'h0)
    else $error("pad not zero");
  AST_TX_PAD: assert property (load && sel_tx |=> shift_q[51:49] == 3'h0)
    else $error("transmit pad not zero");

  // serializer pacing, transmit pending and sent count checks
  AST_NIB_OUT: assert property (state_q == SSVO_SHIFT && link_fall && nib_left_q != 4'h0
                                |=> vec_data_q == $past(shift_q[3:0]))
    else $error("nibble out of order");
  AST_DRAIN_HIGH: assert property (state_q == SSVO_SHIFT && link_fall && nib_left_q == 4'h0
                                   |=> state_q == SSVO_IDLE && vec_data_q == SSVO_IDLE_NIB)
    else $error("lines not released high after vector");
  AST_TX_PEND: assert property (tx_ev[0] |=> tx_pend_q[0])
    else $error("transmit event not pending");
  AST_SENT_COUNT: assert property (load |=> sent_q == 32'($past(sent_q) + 32'h1))
    else $error("started vector not counted");

  // main scenarios
  COV_RX: cover property (load && !sel_tx);
  COV_LOST: cover property (|lost_ev);
  COV_TX: cover property (load && sel_tx);
  COV_BACK: cover property (state_q == SSVO_SHIFT ##1 state_q == SSVO_IDLE ##1 load);

endmodule : ssvo_top

// file: test/ssvo_counter_model.sv
/*
 * ssvo_counter_model: far-end vector parser with raw per-port counters.
 * Assumes vec_data changes after stat_clk falls and is steady at the rise.
 */
`timescale 1ns/1ps
module ssvo_counter_model
  import ssvo_pkg::*;
(
  // vector link
  input wire logic       stat_clk,
  input wire logic [3:0] vec_data
);
  // =========================================================
  // parser state
  logic [63:0] vq[$];        // whole vectors, oldest first
  logic [63:0] acc;
  int          nib = 0;
  logic        gap_seen = 1'b0;
  int          n_gap_err = 0;
  int unsigned rx_cnt[26];   // raw 32-bit counters per port
  int unsigned tx_cnt[26];

  // =========================================================
  // sample on rise
  // parse and count
  // one sample per link rise keeps up with the full peak rate
  always @(posedge stat_clk) begin
    if (nib == 0 && vec_data === SSVO_IDLE_NIB) begin
      gap_seen = 1'b1;
    end else if (nib == 0) begin
      // a start marker straight after a vector means no idle gap
      if (!gap_seen) n_gap_err++;
      gap_seen = 1'b0;
      acc = 64'(vec_data);
      nib = 1;
    end else begin
      acc[4*nib +: 4] = vec_data;
      nib++;
      if (nib == (acc[1] ? 13 : 8)) begin
        vq.push_back(acc);
        if (acc[1]) tx_cnt[acc[6:2]]++;
        else rx_cnt[acc[6:2]]++;
        nib = 0;
      end
    end
  end
endmodule : ssvo_counter_model

// file: test/ssvo_top_bench.sv
/*
 * ssvo_top_bench: directed test of the statistics vector output.
 * Assumes ssvo_top with 26 ports and ssvo_counter_model on the link.
 */
`timescale 1ns/1ps
module ssvo_top_bench
  import ssvo_pkg::*;
;
  // =========================================================
  // stimulus patterns
  localparam ssvo_rx_info_type RX_A = 25'h15A_A95C;
  localparam ssvo_rx_info_type RX_B = 25'h0A5_5A3B;
  localparam ssvo_tx_info_type TX_A = 41'h15A_C3E7_9B1;
  localparam ssvo_tx_info_type TX_B = 41'h0A5_3C18_64E;

  logic                    ref_clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    hsel = 1'b0;
  logic [31:0]             haddr = 32'h0;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic [31:0]             hwdata = 32'h0;
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  logic [25:0]             rx_ev = 26'h0;
  ssvo_rx_info_type [25:0] rx_info = '0;
  logic [25:0]             tx_ev = 26'h0;
  ssvo_tx_info_type [25:0] tx_info = '0;
  logic                    stat_clk = 1'b0;
  logic [3:0]              vec_data;
  int                      n_fail = 0;
  int                      n_tests = 0;

  // clocks; the link clock has its own phase
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #3;
    forever #80 stat_clk = ~stat_clk;
  end

  ssvo_top #(.NPORT(26)) ssvo_top_inst (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_ev(rx_ev),
    .rx_info(rx_info), .tx_ev(tx_ev), .tx_info(tx_info), .stat_clk(stat_clk),
    .vec_data(vec_data));

  ssvo_counter_model ssvo_counter_model_inst (.stat_clk(stat_clk), .vec_data(vec_data));

  // =========================================================
  // reporting
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic timeout(input string what);
    n_fail++;
    $display("unexpected at %0t: no %s in time", $time, what);
    print_verdict();
  endtask : timeout

  task automatic check_reg(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_vec(input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: vector %h, wanted %h", $time, got, exp);
    end
  endtask : check_vec

  // =========================================================
  // bus and event drivers
  task automatic wait_ready();
    int t;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (hreadyout !== 1'b1) timeout("hready");
  endtask : wait_ready

  // address phase held until ready, then data phase until ready
  task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb_xfer

  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] d;
    ahb_xfer(a, 1'b0, 32'h0, d);
    check_reg(exp, d & mask);
  endtask : reg_is

  // one-cycle event pulse with the same status on every port
  task automatic fire(input logic [25:0] rm, input logic [25:0] tm,
                      input ssvo_rx_info_type ri, input ssvo_tx_info_type ti);
    rx_ev <= rm;
    tx_ev <= tm;
    rx_info <= {26{ri}};
    tx_info <= {26{ti}};
    @(posedge ref_clk);
    rx_ev <= 26'h0;
    tx_ev <= 26'h0;
  endtask : fire

  task automatic wait_vec(output logic [63:0] v);
    int t;
    for (t = 0; t < 3000 && ssvo_counter_model_inst.vq.size() == 0; t++) @(posedge ref_clk);
    if (ssvo_counter_model_inst.vq.size() == 0) timeout("vector");
    v = ssvo_counter_model_inst.vq.pop_front();
  endtask : wait_vec

  // =========================================================
  // expected vectors built from the field layout
  function automatic logic [63:0] rx_exp(input logic [4:0] p, input ssvo_rx_info_type i,
                                         input logic imp);
    logic [63:0] v;
    v = 64'h0;
    v[31:19] = {i.fwd_blocked_flag, i.pause_frame_seen, i.ctrl_frame_seen,
                i.ctrl_frame_bad_opcode, i.prior_carrier_flag, i.prior_valid_flag,
                i.good_frame_flag, i.bcast_flag, i.mcast_flag, i.checksum_bad_rx,
                i.partial_byte_flag, i.symbol_error_flag & (p >= SSVO_MII_LOW),
                i.frame_dropped_flag | (i.impure_preamble & imp)};
    v[17:7] = i.in_byte_total;
    v[6:2] = p;
    return v;
  endfunction : rx_exp

  function automatic logic [63:0] tx_exp(input logic [4:0] p, input ssvo_tx_info_type i);
    logic [63:0] v;
    v = 64'h0;
    v[48:19] = i[40:11];
    v[17:7] = i.out_byte_total;
    v[6:2] = p;
    v[1] = 1'b1;
    return v;
  endfunction : tx_exp

  // =========================================================
  // main sequence
  initial begin
    logic [63:0] g;
    logic [63:0] w;
    logic [63:0] e[3];
    logic [31:0] d;
    logic [4:0]  pt[4];
    int          k;
    int          m;
    pt = '{5'h00, 5'h0D, 5'h18, 5'h19};
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // reset values, read-only and unmapped places
    reg_is(SSVO_CTRL_OFS, SSVO_CTRL_RST, 32'hFFFF_FFFF);
    ahb_xfer(SSVO_STAT_OFS, 1'b1, 32'hFFFF_FFFF, d);
    reg_is(SSVO_STAT_OFS, 32'h0, 32'hFFFF_FFFF);
    reg_is(8'h10, 32'h0, 32'hFFFF_FFFF);
    check_reg(32'h0, {31'h0, hresp});
    $display("registers test done");
    // single vectors, edge ports, impure drop off and on
    for (k = 0; k < 4; k++) begin
      ahb_xfer(SSVO_CTRL_OFS, 1'b1, {24'h0, k[1], 7'h01}, d);
      reg_is(SSVO_CTRL_OFS, {24'h0, k[1], 7'h01}, 32'h0000_0081);
      fire(26'h1 << pt[k], 26'h0, k[0] ? RX_B : RX_A, '0);
      wait_vec(g);
      check_vec(rx_exp(pt[k], k[0] ? RX_B : RX_A, k[1]), g);
      fire(26'h0, 26'h1 << pt[k], '0, k[0] ? TX_B : TX_A);
      wait_vec(g);
      check_vec(tx_exp(pt[k], k[0] ? TX_B : TX_A), g);
    end
    $display("single vector test done");
    // simultaneous events leave whole and apart
    ahb_xfer(SSVO_CTRL_OFS, 1'b1, 32'h1, d);
    fire(26'h84, 26'h80, RX_A, TX_B);
    e[0] = rx_exp(5'h02, RX_A, 1'b0);
    e[1] = rx_exp(5'h07, RX_A, 1'b0);
    e[2] = tx_exp(5'h07, TX_B);
    for (k = 0; k < 3; k++) begin
      wait_vec(g);
      w = ~g;
      for (m = 0; m < 3; m++) if (g === e[m]) begin
        w = e[m];
        e[m] = 'x;
      end
      check_vec(w, g);
    end
    check_reg(32'h0, 32'(ssvo_counter_model_inst.n_gap_err));
    $display("shared bus test done");
    // output held off; the newer event replaces the older
    ahb_xfer(SSVO_CTRL_OFS, 1'b1, 32'h0, d);
    fire(26'h200, 26'h0, RX_A, '0);
    @(posedge ref_clk);
    fire(26'h200, 26'h0, RX_B, '0);
    repeat (300) @(posedge ref_clk);
    check_reg(32'h0, 32'(ssvo_counter_model_inst.vq.size()));
    reg_is(SSVO_STAT_OFS, 32'h2, 32'h2);
    reg_is(SSVO_LOST_OFS, 32'h1, 32'hFFFF_FFFF);
    ahb_xfer(SSVO_CTRL_OFS, 1'b1, 32'h1, d);
    wait_vec(g);
    check_vec(rx_exp(5'h09, RX_B, 1'b0), g);
    reg_is(SSVO_SENT_OFS, 32'h0000_000C, 32'hFFFF_FFFF);
    $display("hold-off test done");
    print_verdict();
  end
endmodule : ssvo_top_bench
